/* File: cis_pkg.sv */
// constants, field layouts and carrier types for card interrupt steering
package cis_pkg;

  // terminal count and the widest terminal set the register layout serves
  localparam int CIS_NUM_TERM = 10;
  localparam int CIS_MAX_TERM = 16;

  // register byte offsets; socket b registers sit at the socket a offset
  // plus the socket b base
  localparam logic [7:0] CIS_OFS_IGC = 8'h03;
  localparam logic [7:0] CIS_OFS_CSC = 8'h04;
  localparam logic [7:0] CIS_OFS_CSC_CFG = 8'h05;
  localparam logic [7:0] CIS_OFS_GCTL = 8'h1e;
  localparam logic [7:0] CIS_OFS_MODE_LO = 8'h88;
  localparam logic [7:0] CIS_OFS_MODE_HI = 8'h89;
  localparam logic [7:0] CIS_OFS_MISC = 8'h8a;
  localparam logic [7:0] CIS_SOCK_B_BASE = 8'h40;

  // interrupt and general control: [3:0] io route, [4] card type io
  localparam int CIS_IGC_ROUTE_LSB = 0;
  localparam int CIS_IGC_TYPE_BIT = 4;
  // status-change config: [3:0] flag enables, [7:4] status-change route
  localparam int CIS_CFG_EN_LSB = 0;
  localparam int CIS_CFG_ROUTE_LSB = 4;
  // status-change flag positions
  localparam int CIS_FLG_BVD1 = 0;
  localparam int CIS_FLG_BVD2 = 1;
  localparam int CIS_FLG_READY = 2;
  localparam int CIS_FLG_DETECT = 3;
  // global control bits
  localparam int CIS_GC_SUSPEND = 0;
  localparam int CIS_GC_CSC_LVL = 1;
  localparam int CIS_GC_CLR_WR = 2;
  localparam int CIS_GC_A_LVL = 3;
  localparam int CIS_GC_B_LVL = 4;

  // reset values
  localparam logic [7:0] CIS_IGC_RST = 8'hff;
  localparam logic [7:0] CIS_CFG_RST = 8'hf0;
  localparam logic [7:0] CIS_GCTL_RST = 8'h00;
  localparam logic [15:0] CIS_MODE_RST = 16'h0000;

  // card-side pins of one socket, all active low or level as on the card
  typedef struct packed {
    logic ready_irq;
    logic bvd1;
    logic bvd2;
    logic cd1;
    logic cd2;
  } cis_pins_t;

  localparam cis_pins_t CIS_PINS_RST = 5'h1f;

  // all state of the block
  typedef struct packed {
    logic [7:0] rdata;
    logic [CIS_MAX_TERM-1:0] irq_out;
    logic [CIS_MAX_TERM-1:0] irq_oe;
    logic [CIS_MAX_TERM-1:0] irq_mode;
    logic [1:0][7:0] igc;
    logic [1:0][7:0] csc_cfg;
    logic [1:0][3:0] flags;
    logic [7:0] gctl;
    logic [1:0] card_flag;
    cis_pins_t [1:0] prev;
  } cis_state_t;

endpackage

/* File: cis_top.sv */
// card interrupt steering: routing, status-change flags, terminal drive
//
// Summary of operation
// (R1) Each socket's card I/O interrupt routes to any one of ten terminals.
// (R2) Card pulls ready/irq low to request; pulse or level held.
// (R3) Per-terminal mode bit: one gives totem-pole, zero gives open-drain.
// (R4) Reset clears all terminal mode bits, giving open-drain everywhere.
// (R5) Per-socket level-select bits also pick open-drain for I/O interrupts.
// (R6) Status-change level-select bit also picks open-drain for it.
// (R7) Totem-pole only when the terminal's own mode bit is set.
// (R8) Totem-pole I/O: output low when idle, high while card asserts.
// (R9) Open-drain I/O: floated when idle, driven low while card asserts.
// (R10) Cards sharing a terminal should use level-mode requests.
// (R11) Card asserting its request sets a readable card-interrupt flag.
// (R12) Each socket's status-change interrupt routes to any one terminal.
// (R13) I/O card: battery detect 1 falling is a status-change event.
// (R14) Memory card: battery detect falling or ready change is an event.
// (R15) Any card: either card detect changing level is an event.
// (R16) Totem-pole status change: high while flagged, low once cleared.
// (R17) Open-drain status change: low while flagged, floated once cleared.
// (R18) Flags clear on read or by writing one, per global select bit.
// (R19) Status-change output goes inactive only when all socket flags clear.
// (R20) Suspend keeps state and keeps passing interrupts to terminals.
// (R21) Card type bit decides I/O or memory meaning of card pins.
// (R22) A flag drives the interrupt only with its enable bit set.
// (R23) Flags stay set until cleared, even when the input returns.
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
module cis_top #(
  parameter int NUM_TERMINALS = cis_pkg::CIS_NUM_TERM
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wstrobe,
  input wire logic rstrobe,
  output logic [7:0] rdata,
  // card pins, index 0 is socket a, index 1 socket b
  input cis_pkg::cis_pins_t [1:0] card,
  // host interrupt terminals, enable high while driven
  output logic [NUM_TERMINALS-1:0] irq_out,
  output logic [NUM_TERMINALS-1:0] irq_oe,
  // suspend state, for the card interface power logic
  output logic suspend_request
);
  import cis_pkg::*;

  // mode registers and 4-bit routes cannot address more terminals
  if (NUM_TERMINALS < 1 || NUM_TERMINALS > CIS_MAX_TERM) begin : g_chk
    $error("NUM_TERMINALS out of range");
  end

  cis_state_t st;
  cis_state_t next_st;

  // register hit for a socket-relative offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs,
                               input logic sock);
    return a == (sock ? (ofs | CIS_SOCK_B_BASE) : ofs);
  endfunction

  // route field selects terminal t; values past the last terminal select none
  function automatic logic routed(input logic [3:0] route, input int t);
    return (int'(route) == t) && (t < NUM_TERMINALS);
  endfunction

  logic [1:0] io_type;
  logic [1:0] req_io;
  logic [1:0] rdy_fall;
  logic [1:0][3:0] ev;
  logic [1:0] csc_pend;
  logic [1:0] io_lvl;
  logic [1:0] rd_clr;
  logic [1:0][3:0] wr_clr;

  // per-socket event detection against last cycle's pins
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      io_type[s] = st.igc[s][CIS_IGC_TYPE_BIT]; // (R21)
      req_io[s] = io_type[s] & ~card[s].ready_irq; // (R2)
      rdy_fall[s] = st.prev[s].ready_irq & ~card[s].ready_irq;
      // battery detect 1 falling counts for both card types
      ev[s][CIS_FLG_BVD1] = st.prev[s].bvd1 & ~card[s].bvd1; // (R13) (R14)
      ev[s][CIS_FLG_BVD2] = ~io_type[s] & st.prev[s].bvd2
                            & ~card[s].bvd2; // (R14)
      ev[s][CIS_FLG_READY] = ~io_type[s]
                             & (st.prev[s].ready_irq ^ card[s].ready_irq);
      ev[s][CIS_FLG_DETECT] = (st.prev[s].cd1 ^ card[s].cd1)
                              | (st.prev[s].cd2 ^ card[s].cd2); // (R15)
      csc_pend[s] = |(st.flags[s]
                    & st.csc_cfg[s][CIS_CFG_EN_LSB +: 4]); // (R22) (R19)
      rd_clr[s] = rstrobe & hit(addr, CIS_OFS_CSC, s[0])
                  & ~st.gctl[CIS_GC_CLR_WR]; // (R18)
      wr_clr[s] = (wstrobe & hit(addr, CIS_OFS_CSC, s[0])
                   & st.gctl[CIS_GC_CLR_WR]) ? wdata[3:0] : 4'h0; // (R18)
    end
    io_lvl[0] = st.gctl[CIS_GC_A_LVL]; // (R5)
    io_lvl[1] = st.gctl[CIS_GC_B_LVL]; // (R5)
  end

  // next state: registers, flags, read data and terminal drive
  always_comb begin
    logic act;
    logic lvl;
    logic isa;
    act = 1'b0;
    lvl = 1'b0;
    isa = 1'b0;
    next_st = st;
    next_st.prev = card;
    // set wins over a clear arriving in the same cycle
    for (int s = 0; s < 2; s++) begin
      if (rd_clr[s]) begin
        next_st.flags[s] = ev[s]; // (R18) (R23)
      end else begin
        next_st.flags[s] = (st.flags[s] & ~wr_clr[s]) | ev[s]; // (R23)
      end
    end
    next_st.card_flag = st.card_flag | (rdy_fall & io_type); // (R11)
    // register writes
    if (wstrobe) begin
      for (int s = 0; s < 2; s++) begin
        if (hit(addr, CIS_OFS_IGC, s[0])) begin
          next_st.igc[s] = wdata;
        end
        if (hit(addr, CIS_OFS_CSC_CFG, s[0])) begin
          next_st.csc_cfg[s] = wdata;
        end
      end
      if (addr == CIS_OFS_GCTL) begin
        next_st.gctl = wdata;
      end
      if (addr == CIS_OFS_MODE_LO) begin
        next_st.irq_mode[7:0] = wdata; // (R3)
      end
      if (addr == CIS_OFS_MODE_HI) begin
        next_st.irq_mode[15:8] = wdata; // (R3)
      end
      if (addr == CIS_OFS_MISC) begin
        // write one clears, a new assertion still wins
        next_st.card_flag = (st.card_flag & ~wdata[1:0])
                            | (rdy_fall & io_type); // (R11)
      end
    end
    // read data lives for one cycle only; unmapped reads give zero
    next_st.rdata = 8'h00;
    if (rstrobe) begin
      for (int s = 0; s < 2; s++) begin
        if (hit(addr, CIS_OFS_IGC, s[0])) begin
          next_st.rdata = st.igc[s];
        end
        if (hit(addr, CIS_OFS_CSC, s[0])) begin
          next_st.rdata = {4'h0, st.flags[s]};
        end
        if (hit(addr, CIS_OFS_CSC_CFG, s[0])) begin
          next_st.rdata = st.csc_cfg[s];
        end
      end
      if (addr == CIS_OFS_GCTL) begin
        next_st.rdata = st.gctl;
      end
      if (addr == CIS_OFS_MODE_LO) begin
        next_st.rdata = st.irq_mode[7:0];
      end
      if (addr == CIS_OFS_MODE_HI) begin
        next_st.rdata = st.irq_mode[15:8];
      end
      if (addr == CIS_OFS_MISC) begin
        next_st.rdata = {6'h00, st.card_flag};
      end
    end
    // terminal drive; suspend gates nothing so interrupts pass through
    next_st.irq_out = '0; // (R20)
    next_st.irq_oe = '0;
    for (int t = 0; t < CIS_MAX_TERM; t++) begin
      act = 1'b0;
      lvl = 1'b0;
      for (int s = 0; s < 2; s++) begin
        if (routed(st.igc[s][CIS_IGC_ROUTE_LSB +: 4], t)) begin // (R1)
          act = act | req_io[s];
          lvl = lvl | io_lvl[s];
        end
        if (routed(st.csc_cfg[s][CIS_CFG_ROUTE_LSB +: 4], t)) begin // (R12)
          act = act | csc_pend[s]; // (R19)
          lvl = lvl | st.gctl[CIS_GC_CSC_LVL]; // (R6)
        end
      end
      // a level-select on any source routed here forces open-drain
      isa = st.irq_mode[t] & ~lvl; // (R7)
      if (t < NUM_TERMINALS) begin
        next_st.irq_out[t] = isa & act; // (R8) (R16)
        next_st.irq_oe[t] = isa | act; // (R9) (R17)
      end
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st.rdata <= 8'h00;
      st.irq_out <= '0;
      st.irq_oe <= '0;
      st.irq_mode <= CIS_MODE_RST; // (R4)
      st.igc <= {CIS_IGC_RST, CIS_IGC_RST};
      st.csc_cfg <= {CIS_CFG_RST, CIS_CFG_RST};
      st.flags <= '0;
      st.gctl <= CIS_GCTL_RST;
      st.card_flag <= 2'h0;
      st.prev <= {CIS_PINS_RST, CIS_PINS_RST};
    end else if (ce) begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign irq_out = st.irq_out[NUM_TERMINALS-1:0];
  assign irq_oe = st.irq_oe[NUM_TERMINALS-1:0];
  assign suspend_request = st.gctl[CIS_GC_SUSPEND]; // (R20)

  // helpers for the checks: socket a route and its conditions
  logic [3:0] a_route;
  logic a_isa_ok;
  assign a_route = st.igc[0][3:0];
  assign a_isa_ok = (int'(a_route) < NUM_TERMINALS)
                    && st.igc[1][3:0] != a_route
                    && st.csc_cfg[0][7:4] != a_route
                    && st.csc_cfg[1][7:4] != a_route
                    && !st.gctl[CIS_GC_A_LVL];

  // helpers: socket a status-change route, alone on its terminal
  logic [3:0] c_route;
  logic c_alone;
  logic [3:0] c_pend_bits;
  assign c_route = st.csc_cfg[0][CIS_CFG_ROUTE_LSB +: 4];
  assign c_alone = (int'(c_route) < NUM_TERMINALS)
                   && st.igc[0][3:0] != c_route
                   && st.igc[1][3:0] != c_route
                   && st.csc_cfg[1][7:4] != c_route;
  assign c_pend_bits = st.flags[0] & st.csc_cfg[0][CIS_CFG_EN_LSB +: 4];

  a_isa_io_low: assert property (@(posedge clk) disable iff (reset) // (R8)
    ce && a_isa_ok && st.irq_mode[a_route] && io_type[0]
    && card[0].ready_irq
    |=> !irq_out[$past(a_route)] && irq_oe[$past(a_route)])
    else $error("totem-pole output not low while card idle");

  a_pci_io_float: assert property (@(posedge clk) disable iff (reset) // (R9)
    ce && a_isa_ok && !st.irq_mode[a_route] && io_type[0]
    && card[0].ready_irq
    |=> !irq_oe[$past(a_route)])
    else $error("open-drain output not floated while card idle");

  a_io_level_sel: assert property (@(posedge clk) disable iff (reset) // (R5)
    ce && int'(a_route) < NUM_TERMINALS && st.gctl[CIS_GC_A_LVL]
    |=> !irq_out[$past(a_route)])
    else $error("socket level select did not force open-drain");

  a_csc_level_sel: assert property (@(posedge clk) disable iff (reset) // (R6)
    ce && int'(c_route) < NUM_TERMINALS && st.gctl[CIS_GC_CSC_LVL]
    |=> !irq_out[$past(c_route)])
    else $error("status-change level select did not force open-drain");

  a_csc_isa_high: assert property (@(posedge clk) disable iff (reset) // (R16)
    ce && c_alone && st.irq_mode[c_route] && !st.gctl[CIS_GC_CSC_LVL]
    && c_pend_bits != 4'h0
    |=> irq_out[$past(c_route)] && irq_oe[$past(c_route)])
    else $error("totem-pole status change not high");

  a_csc_pci_low: assert property (@(posedge clk) disable iff (reset) // (R17)
    ce && c_alone && !st.irq_mode[c_route] && c_pend_bits != 4'h0
    |=> !irq_out[$past(c_route)] && irq_oe[$past(c_route)])
    else $error("open-drain status change not low");

  a_csc_inactive: assert property (@(posedge clk) disable iff (reset) // (R19) (R22)
    ce && c_alone && c_pend_bits == 4'h0
    |=> !irq_out[$past(c_route)] && irq_oe[$past(c_route)]
    == $past(st.irq_mode[c_route] && !st.gctl[CIS_GC_CSC_LVL]))
    else $error("status-change output active with no enabled flag");

  a_bvd2_mem_event: assert property (@(posedge clk) disable iff (reset) // (R14)
    ce && !io_type[0] && st.prev[0].bvd2 && !card[0].bvd2
    |=> st.flags[0][CIS_FLG_BVD2])
    else $error("battery detect 2 fall not flagged for memory card");

  a_io_no_bvd2: assert property (@(posedge clk) disable iff (reset) // (R21)
    ce && io_type[0] && !st.flags[0][CIS_FLG_BVD2]
    |=> !st.flags[0][CIS_FLG_BVD2])
    else $error("battery detect 2 flagged for an io card");

  a_write_clears: assert property (@(posedge clk) disable iff (reset) // (R18)
    ce && wr_clr[0] != 4'h0 && ev[0] == 4'h0
    |=> (st.flags[0] & $past(wr_clr[0])) == 4'h0)
    else $error("write of one did not clear the flag");

  a_card_flag_hold: assert property (@(posedge clk) disable iff (reset) // (R11)
    ce && st.card_flag[0]
    && !(wstrobe && addr == CIS_OFS_MISC && wdata[0])
    |=> st.card_flag[0])
    else $error("card interrupt flag lost without a clear");

  a_mode_write: assert property (@(posedge clk) disable iff (reset) // (R3)
    ce && wstrobe && addr == CIS_OFS_MODE_LO
    |=> st.irq_mode[7:0] == $past(wdata))
    else $error("terminal mode bits not written");

  // clock enable low must freeze every flip-flop, read data included
  a_hold_disabled: assert property (@(posedge clk) disable iff (reset)
    !ce |=> st == $past(st))
    else $error("state changed while clock enable low");

  a_reset_modes: assert property (@(posedge clk) // (R4)
    $fell(reset) |-> st.irq_mode == CIS_MODE_RST)
    else $error("mode bits not clear after reset");

  a_isa_io_high: assert property (@(posedge clk) disable iff (reset) // (R8)
    ce && a_isa_ok && st.irq_mode[a_route] && io_type[0]
    && !card[0].ready_irq
    |=> irq_out[$past(a_route)] && irq_oe[$past(a_route)])
    else $error("totem-pole output not high on card request");

  a_pci_io_low: assert property (@(posedge clk) disable iff (reset) // (R9)
    ce && a_isa_ok && !st.irq_mode[a_route] && io_type[0]
    && !card[0].ready_irq
    |=> !irq_out[$past(a_route)] && irq_oe[$past(a_route)])
    else $error("open-drain output not low on card request");

  a_isa_only_mode: assert property (@(posedge clk) disable iff (reset)
    $past(ce) |-> (st.irq_out & ~$past(st.irq_mode)) == '0) // (R7)
    else $error("output driven high without its mode bit");

  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    ce && st.flags[0][CIS_FLG_DETECT] && !rd_clr[0]
    && !wr_clr[0][CIS_FLG_DETECT]
    |=> st.flags[0][CIS_FLG_DETECT]) // (R23)
    else $error("status-change flag lost without a clear");

  a_detect_event: assert property (@(posedge clk) disable iff (reset)
    ce && (card[1].cd1 != st.prev[1].cd1)
    |=> st.flags[1][CIS_FLG_DETECT]) // (R15)
    else $error("card detect change not flagged");

  a_io_bvd1_event: assert property (@(posedge clk) disable iff (reset)
    ce && io_type[0] && st.prev[0].bvd1 && !card[0].bvd1
    |=> st.flags[0][CIS_FLG_BVD1]) // (R13)
    else $error("battery detect fall not flagged");

  a_read_clears: assert property (@(posedge clk) disable iff (reset)
    ce && rd_clr[0] && ev[0] == 4'h0
    |=> st.flags[0] == 4'h0 && rdata == {4'h0, $past(st.flags[0])}) // (R18)
    else $error("read did not clear or return the flags");

  a_card_flag_set: assert property (@(posedge clk) disable iff (reset)
    ce && io_type[1] && rdy_fall[1] |=> st.card_flag[1]) // (R11)
    else $error("card interrupt flag not set");

  a_mem_ready_event: assert property (@(posedge clk) disable iff (reset)
    ce && !io_type[0] && (st.prev[0].ready_irq != card[0].ready_irq)
    |=> st.flags[0][CIS_FLG_READY]) // (R14)
    else $error("ready change not flagged for memory card");

endmodule

/* File: cis_card_model.sv */
// card sockets and host interrupt wires as seen from the block
`timescale 1ns/10ps
module cis_card_model #(
  parameter int NT = 10
) (
  // pin levels the bench asks the cards to show
  input wire cis_pkg::cis_pins_t [1:0] want,
  // terminal drive from the block
  input wire logic [NT-1:0] irq_out,
  input wire logic [NT-1:0] irq_oe,
  // card pins and resolved host wires
  output cis_pkg::cis_pins_t [1:0] card,
  output logic [NT-1:0] irq_wire
);
  import cis_pkg::*;
  // request held low for as long as commanded, so level mode for sharing
  assign card = want;
  // a floated terminal reads high through the host pull-up
  assign irq_wire = (irq_oe & irq_out) | ~irq_oe;
endmodule

/* File: testbench.sv */
// self-checking bench for card interrupt steering
`timescale 1ns/10ps
module testbench;
  import cis_pkg::*;
  logic clk, reset, ce, wstrobe, rstrobe, rd_d, suspend_request;
  logic [7:0] addr, wdata, rdata, g;
  logic [15:0] m;
  logic [31:0] seed;
  cis_pins_t [1:0] want, card;
  logic [9:0] irq_out, irq_oe, irq_wire;
  logic [7:0] exp_q[$];
  int n_fail, check_count, i, s;
  logic [7:0] rst_a[10] = '{CIS_OFS_MODE_LO, CIS_OFS_MODE_HI, CIS_OFS_IGC,
    CIS_OFS_CSC_CFG, CIS_OFS_GCTL, 8'h43, 8'h45, CIS_OFS_MISC, CIS_OFS_CSC,
    8'h20};
  logic [7:0] rst_e[10] = '{CIS_MODE_RST[7:0], CIS_MODE_RST[15:8],
    CIS_IGC_RST, CIS_CFG_RST, CIS_GCTL_RST, CIS_IGC_RST, CIS_CFG_RST,
    8'h00, 8'h00, 8'h00};

  cis_top #(.NUM_TERMINALS(10)) dut_u (.clk(clk), .reset(reset), .ce(ce),
    .addr(addr), .wdata(wdata), .wstrobe(wstrobe), .rstrobe(rstrobe),
    .rdata(rdata), .card(card), .irq_out(irq_out), .irq_oe(irq_oe),
    .suspend_request(suspend_request));
  cis_card_model #(.NT(10)) card_u (.want(want), .irq_out(irq_out),
    .irq_oe(irq_oe), .card(card), .irq_wire(irq_wire));

  // 20 mhz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one-cycle strobes; tasks end on an edge with the strobe dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstrobe <= 1'b1;
    @(posedge clk);
    wstrobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rstrobe <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rstrobe <= 1'b0;
  endtask

  // oe and wire level of one terminal, sampled after updates land
  task automatic term(input int t, input logic isa, input logic act);
    cyc(3);
    #1;
    chk({6'h0, irq_oe[t], irq_wire[t]},
        isa ? {7'h1, act} : {6'h0, act, ~act});
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    rd_d <= rstrobe;
  end

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // the tests need well under a thousand cycles
  initial begin
    #1000000;
    n_fail++;
    $display("FAIL at %0t: timeout", $time);
    stop_test;
  end

  initial begin
    {reset, ce, wstrobe, rstrobe, rd_d} = 5'h18;
    {addr, wdata, n_fail, check_count} = '0;
    want = {CIS_PINS_RST, CIS_PINS_RST};
    seed = 32'hde5d2225;
    cyc(3);
    reset <= 1'b0;
    foreach (rst_a[k]) rd(rst_a[k], rst_e[k]);
    $display("test reset values done");
    // odd terminals totem-pole; 9 forced open-drain, 4 under suspend
    for (i = 0; i < 10; i++) begin
      s = i % 2;
      m = i[0] ? 16'h1 << i : 16'h0;
      g = (i == 9) ? 8'h10 : (i == 4) ? 8'h01 : 8'h00;
      wr(CIS_OFS_MODE_LO, m[7:0]);
      wr(CIS_OFS_MODE_HI, m[15:8]);
      wr(CIS_OFS_GCTL, g);
      wr(CIS_OFS_IGC | (s ? CIS_SOCK_B_BASE : 8'h00), 8'h10 | i[7:0]);
      term(i, i[0] && i != 9, 1'b0);
      want[s].ready_irq <= 1'b0;
      term(i, i[0] && i != 9, 1'b1);
      chk({7'h0, suspend_request}, {7'h0, i == 4});
      want[s].ready_irq <= 1'b1;
      term(i, i[0] && i != 9, 1'b0);
      rd(CIS_OFS_MISC, 8'h01 << s);
      wr(CIS_OFS_MISC, 8'h03);
      wr(CIS_OFS_IGC | (s ? CIS_SOCK_B_BASE : 8'h00), 8'h1f);
    end
    $display("test card interrupts done");
    wr(CIS_OFS_GCTL, 8'h00);
    wr(CIS_OFS_CSC_CFG, 8'h5f);
    wr(CIS_OFS_MODE_LO, 8'h20);
    want[0].bvd1 <= 1'b0;
    term(5, 1'b1, 1'b1);
    want[0].bvd1 <= 1'b1;
    term(5, 1'b1, 1'b1);
    rd(CIS_OFS_CSC, 8'h01);
    term(5, 1'b1, 1'b0);
    // open-drain, clear by write, two flags pending
    wr(CIS_OFS_MODE_LO, 8'h00);
    wr(CIS_OFS_GCTL, 8'h04);
    want[0].cd1 <= 1'b0;
    want[0].bvd1 <= 1'b0;
    term(5, 1'b0, 1'b1);
    rd(CIS_OFS_CSC, 8'h09);
    rd(CIS_OFS_CSC, 8'h09);
    wr(CIS_OFS_CSC, 8'h08);
    term(5, 1'b0, 1'b1);
    wr(CIS_OFS_CSC, 8'h01);
    term(5, 1'b0, 1'b0);
    // memory card meaning of the pins
    want[0].bvd1 <= 1'b1;
    wr(CIS_OFS_IGC, 8'h0f);
    want[0].ready_irq <= 1'b0;
    want[0].bvd2 <= 1'b0;
    term(5, 1'b0, 1'b1);
    rd(CIS_OFS_CSC, 8'h06);
    // clear first, so the release below is a fresh ready change
    wr(CIS_OFS_CSC, 8'h06);
    want[0].ready_irq <= 1'b1;
    want[0].bvd2 <= 1'b1;
    cyc(3);
    rd(CIS_OFS_CSC, 8'h04);
    wr(CIS_OFS_CSC, 8'h04);
    // flag without its enable stays off the terminal
    wr(CIS_OFS_CSC_CFG, 8'h50);
    want[0].cd2 <= 1'b0;
    term(5, 1'b0, 1'b0);
    rd(CIS_OFS_CSC, 8'h08);
    wr(CIS_OFS_CSC, 8'h08);
    // level select overrides the totem-pole mode bit
    wr(CIS_OFS_CSC_CFG, 8'h5f);
    wr(CIS_OFS_MODE_LO, 8'h20);
    wr(CIS_OFS_GCTL, 8'h06);
    want[0].cd2 <= 1'b1;
    term(5, 1'b0, 1'b1);
    wr(CIS_OFS_CSC, 8'h08);
    term(5, 1'b0, 1'b0);
    $display("test status change done");
    // random values through the socket b control register
    for (i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(8'h43, seed[7:0]);
      rd(8'h43, seed[7:0]);
    end
    $display("test random readback done");
    cyc(4);
    stop_test;
  end
endmodule
